// ---- hdl/break_match_pkg.sv ----
// Constants and types shared by the bus-cycle break matcher.
// Assumes a 32-bit classic Wishbone register bus and a same-clock cycle monitor.
package break_match_pkg;

   // ------------------------------------------------------------
   // Register indices; byte address is four times the index
   // ------------------------------------------------------------
   localparam logic [27:0] IDX_ADDR_HIGH  = 28'h5ffff90;
   localparam logic [27:0] IDX_ADDR_LOW   = 28'h5ffff92;
   localparam logic [27:0] IDX_MASK_HIGH  = 28'h5ffff94;
   localparam logic [27:0] IDX_MASK_LOW   = 28'h5ffff96;
   localparam logic [27:0] IDX_CYCLE_SEL  = 28'h5ffff98;
   localparam logic [27:0] IDX_IRQ_STATUS = 28'h5ffff9a;
   localparam logic [27:0] IDX_IRQ_ENABLE = 28'h5ffff9c;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [15:0] RST_BREAK_REG  = 16'h0000;
   localparam logic [1:0]  RST_IRQ_STATUS = 2'h0;
   localparam logic [1:0]  RST_IRQ_ENABLE = 2'h3;

   // ------------------------------------------------------------
   // Field positions of the cycle select register
   // ------------------------------------------------------------
   localparam int POS_MASTER_SEL = 6;
   localparam int POS_FETCH_SEL  = 4;
   localparam int POS_DIR_SEL    = 2;
   localparam int POS_SIZE_SEL   = 0;
   localparam logic [15:0] CYCLE_SEL_USED = 16'h00ff;

   // Status and enable bit positions
   localparam int POS_HIT_CPU = 0;
   localparam int POS_HIT_DMA = 1;

   // Operand size codes of an observed cycle and of the size field
   localparam logic [1:0] SIZE_ANY  = 2'h0;
   localparam logic [1:0] SIZE_BYTE = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_LONG = 2'h3;

   // One observed bus cycle from the CPU or the DMA master
   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
      logic        dma_master;
      logic        fetch;
      logic        write;
      logic [1:0]  size;
   } bus_cycle_t;

endpackage

// ---- hdl/user_break_unit.sv ----
// User break unit: watches CPU and DMA bus cycles and raises a break request.
// Assumes the observed cycle arrives from logic on clk_i, one cycle per valid strobe,
// and a classic Wishbone master with 32-bit data on the register side.
//
// Summary of operation
// - Each observed address is compared with the 32-bit break address built from the high and low halves.
// - Breaks can be limited to cycles of the CPU or of the DMA master, and cycles of both are watched.
// - Breaks can be limited to instruction fetches or to data accesses.
// - Breaks can be limited to byte, word or long word operand size.
// - When every programmed condition matches a cycle, a break interrupt request goes to the CPU.
// - A break on a CPU instruction fetch is signalled in the fetch cycle itself so it lands before execution.
// - Five readable and writable break registers exist, each cleared to zero by reset.
// - Register selection decodes only index bits 27 to 24 and 8 to 0, ignoring bits 23 to 9.
// - A mask bit of 0 keeps the address bit in the compare and a 1 makes that bit always match.
// - Master field 00 never breaks, 01 CPU only, 10 DMA only, 11 both.
// - Fetch/data field 00 never breaks, 01 fetch only, 10 data only, 11 both.
// - Direction field 00 never breaks, 01 read only, 10 write only, 11 both.
//
// Decided for this implementation: register access over Wishbone.

`timescale 1ns/1ps

module user_break_unit (
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   // Wishbone slave
   input  wire logic                         cyc_i,
   input  wire logic                         stb_i,
   input  wire logic                         we_i,
   input  wire logic [31:0]                  adr_i,
   input  wire logic [3:0]                   sel_i,
   input  wire logic [31:0]                  dat_i,
   output logic      [31:0]                  dat_o,
   output logic                              ack_o,
   // Observed bus cycle
   input  wire break_match_pkg::bus_cycle_t  cycle_i,
   // Break outputs
   output logic                              fetch_break_o,
   output logic                              break_irq_o
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------

   // Two-bit select field: bit 0 admits the first kind, bit 1 the second
   function automatic logic field_ok(input logic [1:0] fsel, input logic second);
      field_ok = second ? fsel[1] : fsel[0];
   endfunction

   // Index compare on bits 27..24 and 8..0 only
   function automatic logic idx_hit(input logic [27:0] idx, input logic [27:0] ref_idx);
      idx_hit = (idx[27:24] == ref_idx[27:24]) && (idx[8:0] == ref_idx[8:0]);
   endfunction

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] wdat,
                                              input logic [1:0] lanes);
      lane_merge[7:0]  = lanes[0] ? wdat[7:0]  : old[7:0];
      lane_merge[15:8] = lanes[1] ? wdat[15:8] : old[15:8];
   endfunction

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic [15:0] break_addr_high;
   logic [15:0] break_addr_low;
   logic [15:0] break_mask_high;
   logic [15:0] break_mask_low;
   logic [15:0] break_cycle_select;
   logic [1:0]  irq_status;
   logic [1:0]  irq_enable;

   logic [27:0] reg_idx;
   logic        bus_req;
   logic        wr_stb;
   logic        sel_addr_high;
   logic        sel_addr_low;
   logic        sel_mask_high;
   logic        sel_mask_low;
   logic        sel_cycle;
   logic        sel_status;
   logic        sel_enable;
   logic [15:0] next_rdata;

   assign reg_idx = adr_i[29:2];
   assign bus_req = cyc_i && stb_i && !ack_o;
   assign wr_stb  = bus_req && we_i;

   // Register select, upper index bits 23..9 ignored
   // partial index decode
   assign sel_addr_high = idx_hit(reg_idx, break_match_pkg::IDX_ADDR_HIGH);
   assign sel_addr_low  = idx_hit(reg_idx, break_match_pkg::IDX_ADDR_LOW);
   assign sel_mask_high = idx_hit(reg_idx, break_match_pkg::IDX_MASK_HIGH);
   assign sel_mask_low  = idx_hit(reg_idx, break_match_pkg::IDX_MASK_LOW);
   assign sel_cycle     = idx_hit(reg_idx, break_match_pkg::IDX_CYCLE_SEL);
   assign sel_status    = idx_hit(reg_idx, break_match_pkg::IDX_IRQ_STATUS);
   assign sel_enable    = idx_hit(reg_idx, break_match_pkg::IDX_IRQ_ENABLE);

   // ------------------------------------------------------------
   // Wishbone handshake
   // ------------------------------------------------------------

   // One-cycle acknowledge, unmapped addresses answered too
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= bus_req;
      end
   end

   // Read mux, unmapped and reserved bits read zero
   always_comb begin
      next_rdata = 16'h0000;
      if (sel_addr_high) begin
         next_rdata = break_addr_high;
      end else if (sel_addr_low) begin
         next_rdata = break_addr_low;
      end else if (sel_mask_high) begin
         next_rdata = break_mask_high;
      end else if (sel_mask_low) begin
         next_rdata = break_mask_low;
      end else if (sel_cycle) begin
         next_rdata = break_cycle_select & break_match_pkg::CYCLE_SEL_USED;
      end else if (sel_status) begin
         next_rdata = {14'h0000, irq_status};
      end else if (sel_enable) begin
         next_rdata = {14'h0000, irq_enable};
      end
   end

   // Read data registered with the acknowledge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (bus_req && !we_i) begin
         dat_o <= {16'h0000, next_rdata};
      end
   end

   // ------------------------------------------------------------
   // Break condition registers
   // ------------------------------------------------------------

   // Address and mask halves, byte lanes honoured
   // four registers cleared at reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         break_addr_high <= break_match_pkg::RST_BREAK_REG;
         break_addr_low  <= break_match_pkg::RST_BREAK_REG;
         break_mask_high <= break_match_pkg::RST_BREAK_REG;
         break_mask_low  <= break_match_pkg::RST_BREAK_REG;
      end else if (wr_stb) begin
         if (sel_addr_high) begin
            break_addr_high <= lane_merge(break_addr_high, dat_i[15:0], sel_i[1:0]);
         end
         if (sel_addr_low) begin
            break_addr_low <= lane_merge(break_addr_low, dat_i[15:0], sel_i[1:0]);
         end
         if (sel_mask_high) begin
            break_mask_high <= lane_merge(break_mask_high, dat_i[15:0], sel_i[1:0]);
         end
         if (sel_mask_low) begin
            break_mask_low <= lane_merge(break_mask_low, dat_i[15:0], sel_i[1:0]);
         end
      end
   end

   // Cycle select, reserved upper byte kept at zero
   // cycle select cleared at reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         break_cycle_select <= break_match_pkg::RST_BREAK_REG;
      end else if (wr_stb && sel_cycle) begin
         break_cycle_select <= lane_merge(break_cycle_select, dat_i[15:0], sel_i[1:0])
                               & break_match_pkg::CYCLE_SEL_USED;
      end
   end

   // ------------------------------------------------------------
   // Cycle matching
   // ------------------------------------------------------------
   logic [31:0] break_addr;
   logic [31:0] break_mask;
   logic [1:0]  master_sel;
   logic [1:0]  fetch_data_sel;
   logic [1:0]  dir_sel;
   logic [1:0]  size_sel;
   logic        addr_ok;
   logic        master_ok;
   logic        kind_ok;
   logic        dir_ok;
   logic        size_ok;
   logic        cycle_hit;

   // full 32-bit break address from both halves
   assign break_addr     = {break_addr_high, break_addr_low};
   assign break_mask     = {break_mask_high, break_mask_low};
   assign master_sel     = break_cycle_select[break_match_pkg::POS_MASTER_SEL +: 2];
   assign fetch_data_sel = break_cycle_select[break_match_pkg::POS_FETCH_SEL +: 2];
   assign dir_sel        = break_cycle_select[break_match_pkg::POS_DIR_SEL +: 2];
   assign size_sel       = break_cycle_select[break_match_pkg::POS_SIZE_SEL +: 2];

   // set mask bits drop out of the compare
   assign addr_ok   = ((cycle_i.addr ^ break_addr) & ~break_mask) == 32'h0000_0000;
   // master qualifier; CPU on bit 0, DMA on bit 1
   assign master_ok = field_ok(master_sel, cycle_i.dma_master);
   // cycle type qualifier; fetch on bit 0, data on bit 1
   assign kind_ok   = field_ok(fetch_data_sel, !cycle_i.fetch);
   // read on bit 0, write on bit 1
   assign dir_ok    = field_ok(dir_sel, cycle_i.write);
   // operand size qualifier, zero field admits any size
   assign size_ok   = (size_sel == break_match_pkg::SIZE_ANY) || (size_sel == cycle_i.size);

   // every condition together in one cycle
   assign cycle_hit = cycle_i.valid && addr_ok && master_ok && kind_ok && dir_ok && size_ok;

   // fetch break flagged in the fetch cycle itself
   assign fetch_break_o = cycle_hit && cycle_i.fetch && !cycle_i.dma_master;

   // ------------------------------------------------------------
   // Interrupt status and enable
   // ------------------------------------------------------------
   logic [1:0] hit_vec;
   logic [1:0] clr_vec;

   assign hit_vec[break_match_pkg::POS_HIT_CPU] = cycle_hit && !cycle_i.dma_master;
   assign hit_vec[break_match_pkg::POS_HIT_DMA] = cycle_hit && cycle_i.dma_master;
   assign clr_vec = (wr_stb && sel_status && sel_i[0]) ? dat_i[1:0] : 2'h0;

   // Sticky hits, write one clears, a new hit wins over the clear
   // hit recorded for the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status <= break_match_pkg::RST_IRQ_STATUS;
      end else begin
         irq_status <= (irq_status & ~clr_vec) | hit_vec;
      end
   end

   // Interrupt enable mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_enable <= break_match_pkg::RST_IRQ_ENABLE;
      end else if (wr_stb && sel_enable && sel_i[0]) begin
         irq_enable <= dat_i[1:0];
      end
   end

   // level request while an enabled hit is pending
   assign break_irq_o = |(irq_status & irq_enable);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_wr_addr_low;
      wr_stb && sel_addr_low && (sel_i[1:0] == 2'h3);
   endsequence

   sequence s_cpu_hit;
      cycle_hit && !cycle_i.dma_master;
   endsequence

   chk_hit_sets_irq: assert property (
      s_cpu_hit ##0 irq_enable[0] |=> break_irq_o && irq_status[0])
      else $error("cpu hit did not raise the break request");

   chk_addr_compare: assert property (
      cycle_hit |-> (((cycle_i.addr ^ {break_addr_high, break_addr_low})
                      & ~{break_mask_high, break_mask_low}) == 32'h0000_0000))
      else $error("hit on a mismatching address");

   chk_mask_all_ones: assert property (
      (break_mask == 32'hffff_ffff) && cycle_i.valid && master_ok && kind_ok && dir_ok && size_ok
      |-> cycle_hit)
      else $error("fully masked address failed to match");

   chk_master_none: assert property (
      (master_sel == 2'h0) |-> !cycle_hit)
      else $error("hit with master select off");

   chk_master_dma: assert property (
      cycle_hit && (master_sel == 2'h2) |-> cycle_i.dma_master)
      else $error("cpu cycle hit in dma-only mode");

   chk_fetch_only: assert property (
      cycle_hit && (fetch_data_sel == 2'h1) |-> cycle_i.fetch)
      else $error("data cycle hit in fetch-only mode");

   chk_dir_only: assert property (
      cycle_hit && (dir_sel == 2'h2) |-> cycle_i.write)
      else $error("read cycle hit in write-only mode");

   chk_size_match: assert property (
      cycle_hit && (size_sel != 2'h0) |-> cycle_i.size == size_sel)
      else $error("hit on wrong operand size");

   chk_fetch_same: assert property (
      cycle_hit && cycle_i.fetch && !cycle_i.dma_master |-> fetch_break_o)
      else $error("fetch break not flagged in the fetch cycle");

   chk_all_terms: assert property (
      cycle_hit |-> addr_ok && master_ok && kind_ok && dir_ok && size_ok)
      else $error("hit without every condition");

   chk_reg_write: assert property (
      s_wr_addr_low ##1 !(wr_stb && sel_addr_low) |-> break_addr_low == $past(dat_i[15:0]))
      else $error("break address low did not take the write");

   chk_alias_decode: assert property (
      bus_req && (reg_idx[27:24] == 4'h5) && (reg_idx[8:0] == 9'h198) |-> sel_cycle)
      else $error("aliased index missed the cycle select");

endmodule

// ---- verif/bus_cycle_source.sv ----
// Partner model: the CPU and DMA masters whose bus cycles the break unit watches.
// Assumes one clock shared with the break unit; cycles start just after a rising edge.
`timescale 1ns/1ps

module bus_cycle_source (
   input  wire logic                    clk_i,
   output break_match_pkg::bus_cycle_t  cycle_o
);
   initial cycle_o = '0;

   // ------------------------------------------------------------
   // Cycle driving
   // ------------------------------------------------------------
   // One cycle, held to mid-cycle so the caller can look at it
   task automatic issue(input logic dma, input logic fetch, input logic wr, input logic [1:0] sz,
                        input logic [31:0] a);
      @(posedge clk_i);
      cycle_o <= '{valid: 1'b1, addr: a, dma_master: dma, fetch: fetch, write: wr, size: sz};
      @(negedge clk_i);
   endtask

   // Bus released: qualifiers turn to the inverse, never keep stale values
   task automatic idle();
      @(posedge clk_i);
      cycle_o <= {1'b0, ~cycle_o[36:0]};
   endtask
endmodule

// ---- verif/user_break_unit_test.sv ----
// Testbench for the user break unit: registers over Wishbone, cycles from the partner model.
// Assumes the unit answers each bus request with a one-cycle ack and updates status one edge after a hit.
`timescale 1ns/1ps

module user_break_unit_test;
   localparam int TIME_LIMIT = 20000;
   logic                        clk_i = 1'b0;
   logic                        rst_i = 1'b1;
   logic                        cyc_i = 1'b0;
   logic                        stb_i = 1'b0;
   logic                        we_i = 1'b0;
   logic [31:0]                 adr_i = 32'h0;
   logic [3:0]                  sel_i = 4'h0;
   logic [31:0]                 dat_i = 32'h0;
   logic [31:0]                 dat_o;
   logic                        ack_o;
   break_match_pkg::bus_cycle_t cycle_i;
   logic                        fetch_break_o;
   logic                        break_irq_o;
   int                          err_count = 0;
   int                          total_checks = 0;
   int                          cycles = 0;
   logic [15:0]                 rd;
   logic [31:0]                 baddr = 32'h12345678;
   logic [31:0]                 bmask = 32'h000000f0;
   logic [1:0]                  en = 2'h3;
   logic [27:0]                 regs [5] = '{break_match_pkg::IDX_ADDR_HIGH, break_match_pkg::IDX_ADDR_LOW,
      break_match_pkg::IDX_MASK_HIGH, break_match_pkg::IDX_MASK_LOW, break_match_pkg::IDX_CYCLE_SEL};

   always #20 clk_i = ~clk_i;

   user_break_unit dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cycle_i(cycle_i),
      .fetch_break_o(fetch_break_o), .break_irq_o(break_irq_o));

   bus_cycle_source src_u (.clk_i(clk_i), .cycle_o(cycle_i));

   // Hang guard
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == TIME_LIMIT) begin
         err_count++;
         report_and_stop();
      end
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // Classic single Wishbone cycle, held until ack is sampled high at a rising edge
   task automatic wb(input logic [27:0] idx, input logic w, input logic [15:0] wd, output logic [15:0] r);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {2'h0, idx, 2'h0};
      sel_i <= 4'h3;
      dat_i <= {16'h0, wd};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      if (n >= 50) check("ack", 32'h0, 32'h1);
      r = dat_o[15:0];
      if (!w) check("rdata_upper", dat_o[31:16], 32'h0);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask

   function automatic logic hit(logic [7:0] cs, logic dma, logic fe, logic wr, logic [1:0] sz, logic [31:0] a);
      return (((baddr ^ a) & ~bmask) == 32'h0) && (dma ? cs[7] : cs[6]) && (fe ? cs[4] : cs[5])
         && (wr ? cs[3] : cs[2]) && (cs[1:0] == break_match_pkg::SIZE_ANY || cs[1:0] == sz);
   endfunction

   // One watched cycle, then interrupt, status and clearing
   task automatic run_case(input logic [7:0] cs, input logic dma, input logic fe, input logic wr,
                           input logic [1:0] sz, input logic [31:0] a);
      logic       h;
      logic [1:0] st;
      h = hit(cs, dma, fe, wr, sz, a);
      st = h ? (dma ? 2'h2 : 2'h1) : 2'h0;
      wb(break_match_pkg::IDX_CYCLE_SEL, 1'b1, {8'h0, cs}, rd);
      src_u.issue(dma, fe, wr, sz, a);
      check("fetch_break", fetch_break_o, h & fe & ~dma);
      check("irq_early", break_irq_o, 32'h0);
      src_u.idle();
      @(negedge clk_i);
      check("irq", break_irq_o, |(st & en));
      wb(break_match_pkg::IDX_IRQ_STATUS, 1'b0, 16'h0, rd);
      check("status", rd, st);
      wb(break_match_pkg::IDX_IRQ_STATUS, 1'b1, 16'h3, rd);
      check("irq_clear", break_irq_o, 32'h0);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic test_registers();
      for (int i = 0; i < 5; i++) begin
         wb(regs[i], 1'b0, 16'h0, rd);
         check("reset_value", rd, break_match_pkg::RST_BREAK_REG);
      end
      wb(break_match_pkg::IDX_IRQ_ENABLE, 1'b0, 16'h0, rd);
      check("enable_reset", rd, break_match_pkg::RST_IRQ_ENABLE);
      for (int i = 0; i < 5; i++) begin
         wb(regs[i], 1'b1, 16'ha5c3 ^ 16'(i), rd);
         wb(regs[i], 1'b0, 16'h0, rd);
         check("readback", rd, (i == 4) ? 16'h00c7 : 16'ha5c3 ^ 16'(i));
      end
      wb(regs[0] ^ 28'h0fffe00, 1'b1, 16'h3c5a, rd);
      wb(regs[0], 1'b0, 16'h0, rd);
      check("alias", rd, 16'h3c5a);
      wb(28'h5ffff9e, 1'b1, 16'hffff, rd);
      wb(28'h5ffff9e, 1'b0, 16'h0, rd);
      check("unmapped", rd, 16'h0);
      wb(regs[0], 1'b1, baddr[31:16], rd);
      wb(regs[1], 1'b1, baddr[15:0], rd);
      wb(regs[2], 1'b1, bmask[31:16], rd);
      wb(regs[3], 1'b1, bmask[15:0], rd);
      $display("test registers done");
   endtask

   // Every code of master, fetch/data and direction fields against every cycle kind
   task automatic test_fields();
      logic [7:0] cs;
      for (int f = 0; f < 3; f++)
         for (int c = 0; c < 4; c++)
            for (int j = 0; j < 8; j++) begin
               cs = 8'hfc;
               cs[7 - 2 * f -: 2] = 2'(c);
               run_case(cs, j[0], j[1], j[2], break_match_pkg::SIZE_LONG, baddr);
            end
      for (int s = 0; s < 4; s++)
         for (int z = 1; z < 4; z++)
            run_case(8'hfc | 8'(s), 1'b1, 1'b0, 1'b1, 2'(z), baddr);
      $display("test fields done");
   endtask

   task automatic test_address();
      logic [31:0] flips [5] = '{32'h0, 32'h80, 32'h100, 32'h80000000, 32'h1};
      foreach (flips[k]) run_case(8'hfc, 1'b1, 1'b0, 1'b0, 2'h1, baddr ^ flips[k]);
      // Fully masked address matches anything
      bmask = 32'hffff_ffff;
      wb(break_match_pkg::IDX_MASK_HIGH, 1'b1, bmask[31:16], rd);
      wb(break_match_pkg::IDX_MASK_LOW, 1'b1, bmask[15:0], rd);
      run_case(8'hfc, 1'b0, 1'b1, 1'b1, 2'h2, ~baddr);
      bmask = 32'h0000_00f0;
      wb(break_match_pkg::IDX_MASK_HIGH, 1'b1, bmask[31:16], rd);
      wb(break_match_pkg::IDX_MASK_LOW, 1'b1, bmask[15:0], rd);
      $display("test address done");
   endtask

   task automatic test_enable();
      en = 2'h2;
      wb(break_match_pkg::IDX_IRQ_ENABLE, 1'b1, 16'h2, rd);
      run_case(8'hfc, 1'b0, 1'b1, 1'b0, 2'h3, baddr);
      run_case(8'hfc, 1'b1, 1'b1, 1'b0, 2'h3, baddr);
      en = 2'h3;
      wb(break_match_pkg::IDX_IRQ_ENABLE, 1'b1, 16'h3, rd);
      $display("test enable done");
   endtask

   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      test_registers();
      test_fields();
      test_address();
      test_enable();
      report_and_stop();
   end
endmodule
